// >>> pkg/late_capture_spi_pkg.sv
// constants shared by the late-capture serial master
// assumes a 20 MHz system clock; all link timing is derived from it
package late_capture_spi_pkg;

    // system clock period in picoseconds (20 MHz)
    localparam int CLK_PERIOD_PS = 50_000;

    // flash link: least high or low phase, longest period (9.998 MHz)
    localparam int FLASH_MIN_PHASE_PS = 9_000;
    localparam int FLASH_MAX_PERIOD_PS = 100_000;
    // management link: least high or low phase, longest period (9.998 MHz)
    localparam int MGMT_MIN_PHASE_PS = 11_500;
    localparam int MGMT_MAX_PERIOD_PS = 100_000;

    // least phase rounds up to whole cycles, never below one
    function automatic int ceil_cycles(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // one half period of the link clock in system cycles, fits both links
    localparam int HALF_CYC = (ceil_cycles(FLASH_MIN_PHASE_PS) > ceil_cycles(MGMT_MIN_PHASE_PS))
        ? ceil_cycles(FLASH_MIN_PHASE_PS) : ceil_cycles(MGMT_MIN_PHASE_PS);
    // longest allowed half period, rounded down
    localparam int HALF_CYC_MAX = MGMT_MAX_PERIOD_PS / (2 * CLK_PERIOD_PS);

    localparam int PH_W = 3;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(HALF_CYC - 1);

    // clock pulses per byte in each lane width
    localparam logic [3:0] SINGLE_CLKS = 4'h8;
    localparam logic [3:0] QUAD_CLKS = 4'h2;

    // link select codes
    localparam logic LINK_FLASH = 1'h0;
    localparam logic LINK_MGMT = 1'h1;

    // lane enables for the flash data lines
    localparam logic [3:0] OE_SINGLE = 4'h1;
    localparam logic [3:0] OE_QUAD = 4'hf;
    localparam logic [3:0] OE_NONE = 4'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL} state_t;

endpackage

// >>> src/late_capture_spi_master.sv
// serial master for a flash memory (1 or 4 lanes) and a management chip
// assumes one 20 MHz clock; link data inputs arrive asynchronously from pins
//
// Contract
// - flash mode 0, capture on next launch edge
// - flash lines change on clock or select fall
// - flash clock 9.998-50.01 MHz, phases >= 9 ns
// - management link mode 0, same-edge late capture
// - management output changes on falling edges only
// - management clock 9.998-30.006 MHz, phases >= 11.5 ns
// - management input sampled on falling edge
`timescale 1ns/1ps

module late_capture_spi_master
    import late_capture_spi_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [DATA_W-1:0] i_tx_data,
    input wire logic i_tx_link,
    input wire logic i_tx_quad,
    input wire logic i_tx_read,
    input wire logic i_tx_last,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic [DATA_W-1:0] o_rx_data,
    output logic o_rx_link,
    output logic o_rx_last,
    output logic o_flash_link_clock,
    output logic o_flash_link_select_n,
    input wire logic [3:0] i_flash_link_data_lines,
    output logic [3:0] o_flash_link_data_lines,
    output logic [3:0] o_flash_link_data_lines_oe,
    output logic o_mgmt_link_clock,
    output logic o_mgmt_link_select_n,
    input wire logic i_mgmt_link_data_in,
    output logic o_mgmt_link_data_out
);

    state_t state_q, state_d;
    logic [PH_W-1:0] ph_q, ph_d;
    logic [3:0] bits_q, bits_d;
    logic ph_done, start, chain, load, launch, fall;
    logic hold_v_q, hold_v_d, hold_link_q, hold_quad_q, hold_read_q, hold_last_q;
    logic [DATA_W-1:0] hold_data_q, tx_sh_q, tx_next;
    logic cur_link_q, cur_quad_q, cur_read_q, cur_last_q, link_d;
    logic [4:0] sync1_q, sync2_q;
    logic st0_v_q, st0_end_q, st0_link_q, st0_quad_q, st0_last_q;
    logic st1_v_q, st1_end_q, st1_link_q, st1_quad_q, st1_last_q;
    logic [DATA_W-1:0] rx_sh_q, rx_next;
    logic push, pop, spare_v_q, spare_link_q, spare_last_q;
    logic [DATA_W-1:0] spare_data_q;
    logic [1:0] pend_q;
    logic [2:0] occ;

    // one-word holding stage on the request side
    assign hold_v_d = (hold_v_q && !load) || (i_tx_valid && o_tx_ready);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hold_v_q <= 1'h0;
            o_tx_ready <= 1'h0;
            hold_data_q <= '0;
            hold_link_q <= LINK_FLASH;
            hold_quad_q <= 1'h0;
            hold_read_q <= 1'h0;
            hold_last_q <= 1'h0;
        end
        else
        begin
            hold_v_q <= hold_v_d;
            o_tx_ready <= !hold_v_d;
            if (i_tx_valid && o_tx_ready)
            begin
                hold_data_q <= i_tx_data;
                hold_link_q <= i_tx_link;
                hold_quad_q <= i_tx_quad && (i_tx_link == LINK_FLASH);
                hold_read_q <= i_tx_read;
                hold_last_q <= i_tx_last;
            end
        end
    end

    // bytes in flight plus buffered; a new byte needs a free slot at its end
    assign occ = {2'h0, o_rx_valid} + {2'h0, spare_v_q} + {1'h0, pend_q};
    assign ph_done = (ph_q == PH_LAST);
    assign start = (state_q == ST_IDLE) && hold_v_q && (occ <= 3'h1);
    // back-to-back bytes only when the next one is already here, else frame ends
    assign chain = (state_q == ST_HIGH) && ph_done && (bits_q == 4'h1) && !cur_last_q
        && hold_v_q && (occ == 3'h0) && (hold_link_q == cur_link_q);
    assign load = start || chain;
    assign link_d = load ? hold_link_q : cur_link_q;
    assign tx_next = load ? hold_data_q
        : (cur_quad_q ? {tx_sh_q[DATA_W-5:0], 4'h0} : {tx_sh_q[DATA_W-2:0], 1'h0});

    // sequencing: low half, high half, fall launches next bit
    always_comb
    begin
        state_d = state_q;
        ph_d = ph_q + PH_W'(1);
        bits_d = bits_q;
        launch = 1'h0;
        fall = 1'h0;
        case (state_q)
            ST_IDLE:
            begin
                ph_d = '0;
                if (start)
                begin
                    state_d = ST_LOW;
                    launch = 1'h1;
                end
            end
            ST_LOW:
            begin
                if (ph_done)
                begin
                    state_d = ST_HIGH;
                    ph_d = '0;
                end
            end
            ST_HIGH:
            begin
                if (ph_done)
                begin
                    fall = 1'h1;
                    ph_d = '0;
                    if (bits_q > 4'h1)
                    begin
                        bits_d = bits_q - 4'h1;
                        launch = 1'h1;
                        state_d = ST_LOW;
                    end
                    else if (chain)
                    begin
                        launch = 1'h1;
                        state_d = ST_LOW;
                    end
                    else
                        state_d = ST_TAIL; // select held one half after last fall
                end
            end
            ST_TAIL:
            begin
                if (ph_done)
                begin
                    state_d = ST_IDLE;
                    ph_d = '0;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                ph_d = '0;
            end
        endcase
        if (load)
            bits_d = hold_quad_q ? QUAD_CLKS : SINGLE_CLKS;
    end

    // engine state and current byte
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            ph_q <= '0;
            bits_q <= 4'h0;
            tx_sh_q <= '0;
            cur_link_q <= LINK_FLASH;
            cur_quad_q <= 1'h0;
            cur_read_q <= 1'h0;
            cur_last_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            ph_q <= ph_d;
            bits_q <= bits_d;
            if (launch)
                tx_sh_q <= tx_next;
            if (load)
            begin
                cur_link_q <= hold_link_q;
                cur_quad_q <= hold_quad_q;
                cur_read_q <= hold_read_q;
                cur_last_q <= hold_last_q;
            end
        end
    end

    // pins: clock high only in the high half, select low for the whole frame
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_flash_link_clock <= 1'h0;
            o_flash_link_select_n <= 1'h1;
            o_flash_link_data_lines <= 4'h0;
            o_flash_link_data_lines_oe <= OE_NONE;
            o_mgmt_link_clock <= 1'h0;
            o_mgmt_link_select_n <= 1'h1;
            o_mgmt_link_data_out <= 1'h0;
        end
        else
        begin
            o_flash_link_clock <= (state_d == ST_HIGH) && (link_d == LINK_FLASH);
            o_mgmt_link_clock <= (state_d == ST_HIGH) && (link_d == LINK_MGMT);
            o_flash_link_select_n <= !((state_d != ST_IDLE) && (link_d == LINK_FLASH));
            o_mgmt_link_select_n <= !((state_d != ST_IDLE) && (link_d == LINK_MGMT));
            // launches happen only with a clock fall or the select fall
            if (launch && (link_d == LINK_FLASH))
            begin
                if (load ? hold_quad_q : cur_quad_q)
                begin
                    o_flash_link_data_lines <= tx_next[DATA_W-1 -: 4];
                    o_flash_link_data_lines_oe <= (load ? hold_read_q : cur_read_q)
                        ? OE_NONE : OE_QUAD;
                end
                else
                begin
                    o_flash_link_data_lines <= {3'h0, tx_next[DATA_W-1]};
                    o_flash_link_data_lines_oe <= OE_SINGLE;
                end
            end
            if (launch && (link_d == LINK_MGMT))
                o_mgmt_link_data_out <= tx_next[DATA_W-1];
        end
    end

    // two-flop synchronisers on all incoming data lines
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end
        else
        begin
            sync1_q <= {i_mgmt_link_data_in, i_flash_link_data_lines};
            sync2_q <= sync1_q;
        end
    end

    // capture strobe delayed two cycles so sync2 shows the pin at the fall;
    // this works only because the far end holds until that fall
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st0_v_q <= 1'h0;
            st0_end_q <= 1'h0;
            st0_link_q <= LINK_FLASH;
            st0_quad_q <= 1'h0;
            st0_last_q <= 1'h0;
            st1_v_q <= 1'h0;
            st1_end_q <= 1'h0;
            st1_link_q <= LINK_FLASH;
            st1_quad_q <= 1'h0;
            st1_last_q <= 1'h0;
        end
        else
        begin
            st0_v_q <= fall;
            st0_end_q <= fall && (bits_q == 4'h1);
            st0_link_q <= cur_link_q;
            st0_quad_q <= cur_quad_q;
            st0_last_q <= cur_last_q || !chain;
            st1_v_q <= st0_v_q;
            st1_end_q <= st0_end_q;
            st1_link_q <= st0_link_q;
            st1_quad_q <= st0_quad_q;
            st1_last_q <= st0_last_q;
        end
    end

    // single lane reads line 1, quad reads all four, management its input
    assign rx_next = (st1_link_q == LINK_MGMT) ? {rx_sh_q[DATA_W-2:0], sync2_q[4]}
        : (st1_quad_q ? {rx_sh_q[DATA_W-5:0], sync2_q[3:0]}
        : {rx_sh_q[DATA_W-2:0], sync2_q[1]});
    assign push = st1_v_q && st1_end_q;
    assign pop = o_rx_valid && i_rx_ready;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_sh_q <= '0;
            pend_q <= 2'h0;
        end
        else
        begin
            if (st1_v_q)
                rx_sh_q <= rx_next;
            pend_q <= pend_q + {1'h0, fall && (bits_q == 4'h1)} - {1'h0, push};
        end
    end

    // two-entry receive buffer: output stage plus one spare
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rx_valid <= 1'h0;
            o_rx_data <= '0;
            o_rx_link <= LINK_FLASH;
            o_rx_last <= 1'h0;
            spare_v_q <= 1'h0;
            spare_data_q <= '0;
            spare_link_q <= LINK_FLASH;
            spare_last_q <= 1'h0;
        end
        else if (!o_rx_valid || pop)
        begin
            if (spare_v_q)
            begin
                o_rx_valid <= 1'h1;
                o_rx_data <= spare_data_q;
                o_rx_link <= spare_link_q;
                o_rx_last <= spare_last_q;
                spare_v_q <= push;
                spare_data_q <= rx_next;
                spare_link_q <= st1_link_q;
                spare_last_q <= st1_last_q;
            end
            else
            begin
                o_rx_valid <= push;
                o_rx_data <= rx_next;
                o_rx_link <= st1_link_q;
                o_rx_last <= st1_last_q;
            end
        end
        else if (push)
        begin
            spare_v_q <= 1'h1;
            spare_data_q <= rx_next;
            spare_link_q <= st1_link_q;
            spare_last_q <= st1_last_q;
        end
    end

    // checks on the pin behaviour and on the capture strobe timing
    flash_lines_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $changed(o_flash_link_data_lines)
        |-> ($fell(o_flash_link_clock) || $fell(o_flash_link_select_n)))
        else $error("flash data changed off a falling edge");
    mgmt_dout_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $changed(o_mgmt_link_data_out)
        |-> ($fell(o_mgmt_link_clock) || $fell(o_mgmt_link_select_n)))
        else $error("management output changed off a falling edge");
    flash_clock_rate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_flash_link_clock)
        |=> (o_flash_link_clock or (!o_flash_link_clock ##1 o_flash_link_select_n)))
        else $error("flash clock period too long");
    mgmt_high_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_mgmt_link_clock) |=> !o_mgmt_link_clock ##1 (o_mgmt_link_clock
        or o_mgmt_link_select_n or (!o_mgmt_link_clock ##1 o_mgmt_link_select_n)))
        else $error("management clock phase out of range");
    idle_clock_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_flash_link_select_n |-> !o_flash_link_clock)
        and (o_mgmt_link_select_n |-> !o_mgmt_link_clock))
        else $error("link clock high while deselected");
    select_before_clock_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_flash_link_clock) |-> !$past(o_flash_link_select_n))
        else $error("flash clock rose without prior select");
    flash_late_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_flash_link_clock) |-> ##1 (st1_v_q && st1_link_q == LINK_FLASH))
        else $error("flash capture not tied to falling edge");
    mgmt_late_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_mgmt_link_clock) |-> ##1 (st1_v_q && st1_link_q == LINK_MGMT))
        else $error("management capture not tied to falling edge");
    mgmt_same_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (st0_v_q && st0_link_q == LINK_MGMT) |-> $fell(o_mgmt_link_clock))
        else $error("management sample not on launch edge");

endmodule

// >>> bench/link_partner_model.sv
// far side model: serial flash memory and management chip, behavioural
// assumes the bench resolves the shared flash lines from the master's enables
`timescale 1ns/1ps

module link_partner_model
(
    input wire logic i_fclk,
    input wire logic i_fsel_n,
    input wire logic [3:0] i_flines,
    input wire logic i_quad,
    input wire logic i_slow,
    input wire logic [7:0] i_reply,
    input wire logic i_mclk,
    input wire logic i_msel_n,
    input wire logic i_mdata,
    output logic [3:0] o_flines = 4'h0,
    output logic o_mdata = 1'b0,
    output logic [7:0] o_fseen = 8'h00,
    output logic [7:0] o_mseen = 8'h00
);
    logic [7:0] fsh = 8'h00;
    logic [7:0] msh = 8'h00;
    logic [3:0] fnext;
    int fcnt = 0;
    int mcnt = 0;

    // reply loads as select falls, then each clock fall moves on
    always @(negedge i_fsel_n)
    begin
        fcnt = 0;
        fsh = i_reply;
    end
    always @(negedge i_fclk)
    begin
        fsh = i_quad ? {fsh[3:0], 4'h0} : {fsh[6:0], 1'b0};
        fcnt = fcnt + (i_quad ? 4 : 1);
        if (fcnt >= 8)
        begin
            fcnt = 0;
            fsh = i_reply;
        end
    end
    // single mode answers on lane 1; unselected lines show the inverse
    assign fnext = i_quad ? fsh[7:4] : {~fsh[7], ~fsh[7], fsh[7], ~fsh[7]};
    // slow mode lags, but the bit still stands until the next fall
    always @(fnext or i_fsel_n)
        o_flines <= #(i_slow ? 35 : 3) (i_fsel_n ? ~fnext : fnext);
    // same scheme on the management link, one bit per clock
    always @(negedge i_msel_n)
    begin
        mcnt = 0;
        msh = i_reply;
    end
    always @(negedge i_mclk)
    begin
        msh = (mcnt == 7) ? i_reply : {msh[6:0], 1'b0};
        mcnt = (mcnt + 1) % 8;
    end
    always @(msh or i_msel_n)
        o_mdata <= #(i_slow ? 35 : 3) (i_msel_n ? ~msh[7] : msh[7]);
    // far side samples on the rising edge, opposite to the launch
    always @(posedge i_fclk)
        o_fseen <= i_quad ? {o_fseen[3:0], i_flines} : {o_fseen[6:0], i_flines[0]};
    always @(posedge i_mclk)
        o_mseen <= {o_mseen[6:0], i_mdata};
endmodule

// >>> bench/tb_top.sv
// bench for the late-capture serial master: modes, chaining, buffer stall
// assumes link_partner_model on both links and the shared package
`timescale 1ns/1ps

module tb_top;
    import late_capture_spi_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_tx_valid = 1'b0;
    logic i_tx_link = 1'b0;
    logic i_tx_quad = 1'b0;
    logic i_tx_read = 1'b0;
    logic i_tx_last = 1'b0;
    logic i_rx_ready = 1'b0;
    logic [7:0] i_tx_data = 8'h00;
    logic quad = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reply = 8'h00;
    logic o_tx_ready, o_rx_valid, o_rx_link, o_rx_last, o_mgmt_link_data_out;
    logic o_flash_link_clock, o_flash_link_select_n, o_mgmt_link_clock, o_mgmt_link_select_n;
    logic i_mgmt_link_data_in;
    logic [7:0] o_rx_data, fseen, mseen;
    logic [3:0] o_flash_link_data_lines, o_flash_link_data_lines_oe, mlines;
    logic [3:0] i_flash_link_data_lines;
    int err_total = 0;
    int checked = 0;

    // 20 MHz system clock
    always #25 i_clk = ~i_clk;
    // a lane carries the master's bit while enabled, else the far side's
    assign i_flash_link_data_lines = (o_flash_link_data_lines & o_flash_link_data_lines_oe)
        | (mlines & ~o_flash_link_data_lines_oe);

    late_capture_spi_master #(.DATA_W(8)) dut
    (
        .i_clk, .i_rst_b, .i_tx_valid, .o_tx_ready, .i_tx_data, .i_tx_link, .i_tx_quad,
        .i_tx_read, .i_tx_last, .o_rx_valid, .i_rx_ready, .o_rx_data, .o_rx_link, .o_rx_last,
        .o_flash_link_clock, .o_flash_link_select_n, .i_flash_link_data_lines,
        .o_flash_link_data_lines, .o_flash_link_data_lines_oe, .o_mgmt_link_clock,
        .o_mgmt_link_select_n, .i_mgmt_link_data_in, .o_mgmt_link_data_out
    );

    link_partner_model far_side
    (
        .i_fclk(o_flash_link_clock), .i_fsel_n(o_flash_link_select_n),
        .i_flines(i_flash_link_data_lines), .i_quad(quad), .i_slow(slow), .i_reply(reply),
        .i_mclk(o_mgmt_link_clock), .i_msel_n(o_mgmt_link_select_n),
        .i_mdata(o_mgmt_link_data_out), .o_flines(mlines), .o_mdata(i_mgmt_link_data_in),
        .o_fseen(fseen), .o_mseen(mseen)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // pin watch: data moves only on a launch edge, clocks idle low, high time
    logic pf_clk = 1'b0, pf_sel = 1'b1, pm_clk = 1'b0, pm_sel = 1'b1, pm_out = 1'b0;
    logic [3:0] pf_out = 4'h0;
    int fhi = 0;
    int mhi = 0;
    always @(posedge i_clk)
    begin
        if (i_rst_b && !pf_sel && !o_flash_link_select_n && o_flash_link_data_lines !== pf_out)
            chk(pf_clk && !o_flash_link_clock, 1'b1, "flash lines off a fall");
        if (i_rst_b && !pm_sel && !o_mgmt_link_select_n && o_mgmt_link_data_out !== pm_out)
            chk(pm_clk && !o_mgmt_link_clock, 1'b1, "mgmt out off a fall");
        if (i_rst_b && ((o_flash_link_select_n & o_flash_link_clock)
            | (o_mgmt_link_select_n & o_mgmt_link_clock)))
            chk(1'b1, 1'b0, "clock high outside frame");
        if (pf_clk && !o_flash_link_clock)
            chk(fhi >= HALF_CYC && fhi <= HALF_CYC_MAX, 1'b1, "flash high time");
        if (pm_clk && !o_mgmt_link_clock)
            chk(mhi >= HALF_CYC && mhi <= HALF_CYC_MAX, 1'b1, "mgmt high time");
        fhi = o_flash_link_clock ? fhi + 1 : 0;
        mhi = o_mgmt_link_clock ? mhi + 1 : 0;
        {pf_clk, pf_sel, pf_out} = {o_flash_link_clock, o_flash_link_select_n,
            o_flash_link_data_lines};
        {pm_clk, pm_sel, pm_out} = {o_mgmt_link_clock, o_mgmt_link_select_n, o_mgmt_link_data_out};
    end

    // one request word held until taken; any limit but 400 expects refusal
    task automatic push(input logic [7:0] d, input logic lk, qd, rd, ls, input int lim);
        int n;
        logic took;
        n = 0;
        @(posedge i_clk);
        #1 {i_tx_data, i_tx_link, i_tx_quad, i_tx_read, i_tx_last} = {d, lk, qd, rd, ls};
        i_tx_valid = 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_tx_ready !== 1'b1 && n < lim);
        took = o_tx_ready;
        chk(took, {7'h00, lim == 400}, "request handshake");
        #1 i_tx_valid = 1'b0;
        if (lim == 400 && took !== 1'b1)
            tally_and_finish();
    endtask

    // accept one received byte and compare all that it carries
    task automatic pop(input logic [7:0] d, input logic lk, ls);
        int n;
        n = 0;
        @(posedge i_clk);
        #1 i_rx_ready = 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_rx_valid !== 1'b1 && n < 400);
        chk(o_rx_valid, 1'b1, "received byte present");
        chk(o_rx_data, d, "received byte");
        chk({o_rx_link, o_rx_last}, {6'h00, lk, ls}, "link and frame end");
        #1 i_rx_ready = 1'b0;
        if (n >= 400)
            tally_and_finish();
    endtask

    // every lane mode once: ctl {link, quad, read}, sent, reply, received, seen
    task automatic t_modes();
        logic [39:0] row [4];
        row = '{40'h00_a53c_3ca5, 40'h02_5ac3_5a5a, 40'h03_00e7_e7e7, 40'h04_9669_6996};
        foreach (row[i])
        begin
            reply = row[i][23:16];
            quad = row[i][33];
            push(row[i][31:24], row[i][34], row[i][33], row[i][32], 1'b1, 400);
            pop(row[i][15:8], row[i][34], 1'b1);
            chk(row[i][34] ? mseen : fseen, row[i][7:0], "far side saw");
            // enables stand after the frame; a management frame leaves the last ones
            chk(o_flash_link_data_lines_oe, (row[i][34] || (row[i][33] && row[i][32]))
                ? OE_NONE : (row[i][33] ? OE_QUAD : OE_SINGLE), "lane enables");
        end
        $display("test lane modes done");
    endtask

    // two words in one flash frame, the second queued while the first runs
    task automatic t_chain();
        quad = 1'b0;
        reply = 8'h81;
        push(8'ha1, LINK_FLASH, 1'b0, 1'b0, 1'b0, 400);
        push(8'hb2, LINK_FLASH, 1'b0, 1'b0, 1'b1, 400);
        pop(8'h81, LINK_FLASH, 1'b0);
        pop(8'h81, LINK_FLASH, 1'b1);
        chk(fseen, 8'hb2, "second word sent");
        $display("test chained frame done");
    endtask

    // consumer stalls and the far side answers late: buffer fills, refuses, drains
    task automatic t_full();
        slow = 1'b1;
        reply = 8'h42;
        push(8'h11, LINK_MGMT, 1'b0, 1'b0, 1'b1, 400);
        push(8'h22, LINK_MGMT, 1'b0, 1'b0, 1'b1, 400);
        push(8'h33, LINK_MGMT, 1'b0, 1'b0, 1'b1, 400);
        push(8'h44, LINK_MGMT, 1'b0, 1'b0, 1'b1, 60);
        repeat (3) pop(8'h42, LINK_MGMT, 1'b1);
        @(posedge i_clk);
        chk(o_rx_valid, 1'b0, "buffer empty");
        chk(mseen, 8'h33, "last word sent");
        $display("test full buffer done");
    endtask

    initial
    begin
        repeat (8) @(posedge i_clk);
        chk({o_flash_link_clock, o_flash_link_select_n, o_mgmt_link_clock,
            o_mgmt_link_select_n, o_flash_link_data_lines_oe}, 8'h50, "reset pins");
        chk({o_tx_ready, o_rx_valid}, 8'h00, "reset handshakes");
        #1 i_rst_b = 1'b1;
        t_modes();
        t_chain();
        t_full();
        tally_and_finish();
    end
endmodule
